// ===== verilog/cfg_front_consts.vh
// Purpose: constants of the configuration unit host front end
// Assumes: 100 MHz mclk_in
// Notes:   opcodes occupy packet bits [31:28]
`ifndef CFG_FRONT_CONSTS_VH
`define CFG_FRONT_CONSTS_VH

// packet fields
`define OP_HI           31
`define OP_LO           28
`define ADDR_HI         23
`define ADDR_LO         0
`define REGIDX_HI       3

// opcodes
`define OP_NOP          4'h0
`define OP_REG_WRITE    4'h2
`define OP_REG_READ     4'h3
`define OP_CMEM_WRITE   4'hA
`define OP_RING_WRITE   4'hB

// write targets
`define TGT_CTRL        2'h0
`define TGT_CMEM        2'h1
`define TGT_RING        2'h2

// control register 0 fields
`define CTL_RUN_BIT     0

// reset values
`define RST_WORD        32'h0000_0000
`define RST_CS_N        4'hF

// timing counts (mclk cycles)
`define HK_CYCLES       16'h0100
`define SCK_HALF        8'h04
`define STARTUP_CYCLES  16'h0020

`endif

// ===== verilog/config_unit_front.v
// Purpose: host port, flash port and instruction front end of the configuration unit
// Assumes: host clock, pins and test pins are asynchronous to mclk_in and oversampled
// Notes:   one 32-word fifo sits between the ports and the packet executor
//
// Contract
// - flash pause pauses traffic; chip select held, serial clock keeps running
// - four active-low flash selects; single mode drives only select 0
// - serial flash clock made here; pause output changes on its falling edge while the flash owns the pins
// - host data bus is synchronised and sampled in the mclk_in domain on detected host clock rises
// - data pins serve either processor port or flash, never both
// - valid output high exactly while read-back data stands on the bus
// - host clock may begin with either edge after start-up
// - status outputs come from flops reset to zero (host busy resets to one), rising cleanly
// - after reset release housekeeping runs alone, clearing config memory
// - instructions arriving during housekeeping are discarded
// - config status low in housekeeping, high after, then processing starts
// - instructions taken in 128-bit groups, executed one 32-bit packet per clock
// - device stalls the host while busy; host watches status before sending
// - decoded writes routed to core memory, ring memory or control registers
// - core reset sequenced for startup, reasserted at once when the run bit clears
// - test port: async active-low reset, serial pins follow test clock
// - strap bit 0 set gates off the port chip select
`timescale 1ns/100ps
`default_nettype none
`include "cfg_front_consts.vh"

module cfg_word_fifo #(
    parameter W  = 32,
    parameter D  = 32,
    parameter AW = 5
) (
    input  wire         mclk_in,
    input  wire         rstn_in,
    // fill side
    input  wire [W-1:0] in_data_in,
    input  wire         in_valid_in,
    output wire         in_ready_out,
    // drain side
    output wire [W-1:0] out_data_out,
    output wire         out_valid_out,
    input  wire         out_ready_in
);
    reg  [W-1:0] mem [0:D-1];
    reg  [AW:0]  wp_q;
    reg  [AW:0]  rp_q;
    wire         full;
    wire         empty;

    assign full          = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty         = (wp_q == rp_q);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem[rp_q[AW-1:0]];

    always @(posedge mclk_in) begin
        if (in_valid_in && !full)
            mem[wp_q[AW-1:0]] <= in_data_in;
        if (!rstn_in) begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end else begin
            if (in_valid_in && !full)
                wp_q <= wp_q + 1'b1;
            if (out_ready_in && !empty)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule // cfg_word_fifo

module config_unit_front #(
    parameter HK_CNT    = `HK_CYCLES,
    parameter START_CNT = `STARTUP_CYCLES,
    parameter FIFO_D    = 32,
    parameter FIFO_AW   = 5
) (
    // clock and configuration reset
    input  wire        mclk_in,
    input  wire        rstn_in,
    // processor port
    input  wire        host_clk_in,
    input  wire        host_cs_n_in,
    input  wire [31:0] dq_in,
    output reg  [31:0] dq_out,
    output reg         dq_oe_n_out,
    output reg         dq_valid_out,
    output reg         host_busy_out,
    // mode and straps
    input  wire        flash_mode_in,
    input  wire [2:0]  test_strap_in,
    // flash port
    input  wire        flash_go_in,
    input  wire        flash_quad_in,
    input  wire [1:0]  flash_sel_in,
    input  wire        flash_pause_req_in,
    output reg         flash_sck_out,
    output reg  [3:0]  flash_cs_n_out,
    output reg         flash_pause_n_out,
    // status and core control
    output reg         config_status_out,
    output reg         cmem_clear_out,
    output reg         core_rst_n_out,
    output reg         cfg_wr_out,
    output reg  [1:0]  cfg_tgt_out,
    output reg  [23:0] cfg_addr_out,
    output reg  [31:0] cfg_data_out,
    // test port
    input  wire        test_port_reset_n_in,
    input  wire        test_clk_in,
    input  wire        test_mode_in,
    input  wire        test_di_in,
    output reg         test_do_out
);
    // two-flop synchronisers for every pin except test_port_reset_n_in and strap bits 2:1
    reg [31:0] dq_s1_q, dq_s2_q;
    reg [11:0] p_s1_q,  p_s2_q;
    always @(posedge mclk_in) begin
        if (!rstn_in) begin
            dq_s1_q <= `RST_WORD;
            dq_s2_q <= `RST_WORD;
            p_s1_q  <= 12'h802;
            p_s2_q  <= 12'h802;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            p_s1_q  <= {test_strap_in[0], flash_sel_in, flash_quad_in,
                        test_di_in, test_mode_in, test_clk_in, flash_pause_req_in,
                        flash_go_in, flash_mode_in, host_cs_n_in, host_clk_in};
            p_s2_q  <= p_s1_q;
        end
    end
    wire hclk_s  = p_s2_q[0];
    wire cs_n_s  = p_s2_q[1] | p_s2_q[11];
    wire       fquad_s = p_s2_q[8];
    wire [1:0] fsel_s  = p_s2_q[10:9];
    wire fmode_s = p_s2_q[2];
    wire fgo_s   = p_s2_q[3];
    wire fpause_s= p_s2_q[4];
    wire tck_s   = p_s2_q[5];
    wire tms_s   = p_s2_q[6];
    wire tdi_s   = p_s2_q[7];

    // housekeeping phase
    reg        hk_q;
    reg [15:0] hk_cnt_q;
    always @(posedge mclk_in) begin
        if (!rstn_in) begin
            hk_q              <= 1'b1;
            hk_cnt_q          <= 16'h0000;
            cmem_clear_out    <= 1'b0;
            config_status_out <= 1'b0;
        end else if (hk_q) begin
            hk_cnt_q       <= hk_cnt_q + 16'h0001;
            cmem_clear_out <= (hk_cnt_q != HK_CNT[15:0] - 16'h0001);
            if (hk_cnt_q == HK_CNT[15:0] - 16'h0001) begin
                hk_q              <= 1'b0;
                config_status_out <= 1'b1;
            end
        end
    end

    // host clock edges; first sample primes, so either start edge is safe
    reg hclk_prev_q, primed_q;
    always @(posedge mclk_in) begin
        if (!rstn_in) begin
            hclk_prev_q <= 1'b0;
            primed_q    <= 1'b0;
        end else begin
            hclk_prev_q <= hclk_s;
            primed_q    <= 1'b1;
        end
    end
    wire hrise = primed_q && hclk_s && !hclk_prev_q;
    wire hfall = primed_q && !hclk_s && hclk_prev_q;

    // port ownership and write capture
    wire cpu_own  = !fmode_s;
    wire fl_own   = fmode_s && !hk_q && fgo_s;
    wire fifo_rdy;
    wire cpu_push = hrise && cpu_own && !cs_n_s && dq_oe_n_out && !hk_q;

    // flash serial clock, selects and pause
    reg  [7:0] div_q;
    reg        fl_push_q;
    wire       sck_tick = (div_q == `SCK_HALF - 8'h01);
    always @(posedge mclk_in) begin
        if (!rstn_in) begin
            div_q             <= 8'h00;
            flash_sck_out     <= 1'b0;
            flash_cs_n_out    <= `RST_CS_N;
            flash_pause_n_out <= 1'b1;
            fl_push_q         <= 1'b0;
        end else begin
            fl_push_q <= 1'b0;
            if (!fl_own) begin
                // a high half period is finished before the clock parks low
                div_q <= (flash_sck_out && !sck_tick) ? div_q + 8'h01 : 8'h00;
                if (sck_tick)
                    flash_sck_out <= 1'b0;
                flash_cs_n_out <= `RST_CS_N;
                flash_pause_n_out <= 1'b1;
            end else begin
                // select stays low through a pause
                flash_cs_n_out <= fquad_s ? ~(4'h1 << fsel_s) : 4'hE;
                div_q <= sck_tick ? 8'h00 : div_q + 8'h01;
                if (sck_tick) begin
                    flash_sck_out <= !flash_sck_out;
                    if (flash_sck_out)
                        flash_pause_n_out <= !(fpause_s || !fifo_rdy);
                    else
                        fl_push_q <= flash_pause_n_out;
                end
            end
        end
    end

    // fifo between ports and executor
    wire [31:0] ff_data;
    wire        ff_valid;
    wire        ff_take;
    cfg_word_fifo #(.W(32), .D(FIFO_D), .AW(FIFO_AW)) u_fifo (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .in_data_in   (dq_s2_q),
        .in_valid_in  (cpu_push || (fl_push_q && fl_own)),
        .in_ready_out (fifo_rdy),
        .out_data_out (ff_data),
        .out_valid_out(ff_valid),
        .out_ready_in (ff_take)
    );

    always @(posedge mclk_in) begin
        if (!rstn_in)
            host_busy_out <= 1'b1;
        else
            host_busy_out <= hk_q || !fifo_rdy;
    end

    // executor: collect four words, run four packets
    reg [127:0] grp_q;
    reg [1:0]   wcnt_q;
    reg         exec_q;
    reg [1:0]   pcnt_q;
    reg [3:0]   pend_q;
    reg [23:0]  paddr_q;
    reg [31:0]  ctl_q [0:15];
    reg         rd_pend_q;
    reg [31:0]  rd_word_q;
    wire [31:0] pkt = grp_q[127:96];
    wire [3:0]  op  = pkt[`OP_HI:`OP_LO];
    assign ff_take = !exec_q && !hk_q;
    integer i;

    function [1:0] tgt_of;
        input [3:0] o;
        begin
            tgt_of = (o == `OP_CMEM_WRITE) ? `TGT_CMEM :
                     (o == `OP_RING_WRITE) ? `TGT_RING : `TGT_CTRL;
        end
    endfunction

    always @(posedge mclk_in) begin
        if (!rstn_in) begin
            grp_q     <= 128'h0;
            wcnt_q    <= 2'h0;
            exec_q    <= 1'b0;
            pcnt_q    <= 2'h0;
            pend_q    <= `OP_NOP;
            paddr_q   <= 24'h00_0000;
            rd_pend_q <= 1'b0;
            rd_word_q <= `RST_WORD;
            cfg_wr_out   <= 1'b0;
            cfg_tgt_out  <= `TGT_CTRL;
            cfg_addr_out <= 24'h00_0000;
            cfg_data_out <= `RST_WORD;
            for (i = 0; i < 16; i = i + 1)
                ctl_q[i] <= `RST_WORD;
        end else begin
            cfg_wr_out <= 1'b0;
            if (hfall && dq_valid_out)
                rd_pend_q <= 1'b0;
            if (!exec_q) begin
                if (ff_valid && ff_take) begin
                    grp_q  <= {grp_q[95:0], ff_data};
                    wcnt_q <= wcnt_q + 2'h1;
                    if (wcnt_q == 2'h3)
                        exec_q <= 1'b1;
                end
            end else begin
                grp_q  <= {grp_q[95:0], 32'h0000_0000};
                pcnt_q <= pcnt_q + 2'h1;
                if (pcnt_q == 2'h3)
                    exec_q <= 1'b0;
                if (pend_q != `OP_NOP) begin
                    cfg_wr_out   <= 1'b1;
                    cfg_tgt_out  <= tgt_of(pend_q);
                    cfg_addr_out <= paddr_q;
                    cfg_data_out <= pkt;
                    if (pend_q == `OP_REG_WRITE)
                        ctl_q[paddr_q[`REGIDX_HI:0]] <= pkt;
                    pend_q <= `OP_NOP;
                end else if (op == `OP_REG_WRITE || op == `OP_CMEM_WRITE ||
                             op == `OP_RING_WRITE) begin
                    pend_q  <= op;
                    paddr_q <= pkt[`ADDR_HI:`ADDR_LO];
                end else if (op == `OP_REG_READ) begin
                    rd_word_q <= ctl_q[pkt[`REGIDX_HI:0]];
                    rd_pend_q <= 1'b1;
                end
            end
        end
    end

    // read-back on host falling edge, held one host period
    always @(posedge mclk_in) begin
        if (!rstn_in) begin
            dq_out       <= `RST_WORD;
            dq_oe_n_out  <= 1'b1;
            dq_valid_out <= 1'b0;
        end else if (hfall) begin
            if (dq_valid_out || !cpu_own) begin
                dq_oe_n_out  <= 1'b1;
                dq_valid_out <= 1'b0;
            end else if (rd_pend_q) begin
                dq_out       <= rd_word_q;
                dq_oe_n_out  <= 1'b0;
                dq_valid_out <= 1'b1;
            end
        end
    end

    // core reset sequencing from control register 0
    reg [15:0] st_cnt_q;
    always @(posedge mclk_in) begin
        if (!rstn_in) begin
            st_cnt_q       <= 16'h0000;
            core_rst_n_out <= 1'b0;
        end else if (!ctl_q[0][`CTL_RUN_BIT]) begin
            st_cnt_q       <= 16'h0000;
            core_rst_n_out <= 1'b0;
        end else if (!core_rst_n_out) begin
            st_cnt_q <= st_cnt_q + 16'h0001;
            if (st_cnt_q == START_CNT[15:0] - 16'h0001)
                core_rst_n_out <= 1'b1;
        end
    end

    // test port bypass path, async reset
    reg tck_prev_q, byp_q;
    always @(posedge mclk_in) begin
        if (!rstn_in)
            tck_prev_q <= 1'b0;
        else
            tck_prev_q <= tck_s;
    end
    always @(posedge mclk_in or negedge test_port_reset_n_in) begin
        if (!test_port_reset_n_in) begin
            byp_q       <= 1'b0;
            test_do_out <= 1'b0;
        end else begin
            if (tck_s && !tck_prev_q)
                byp_q <= tms_s ? 1'b0 : tdi_s;
            if (!tck_s && tck_prev_q)
                test_do_out <= byp_q;
        end
    end
endmodule // config_unit_front
`default_nettype wire

// ===== tb/config_unit_front_chk.sv
// Purpose: port assertions for config_unit_front
// Assumes: synchronous active-low reset on mclk_in
// Notes:   bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module config_unit_front_chk #(
    parameter HK_CNT = 256
) (
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        rstn_in,
    // modes
    input wire logic        flash_mode_in,
    input wire logic        flash_quad_in,
    input wire logic        test_port_reset_n_in,
    // host port
    input wire logic        dq_oe_n_out,
    input wire logic        dq_valid_out,
    input wire logic        host_busy_out,
    // flash port
    input wire logic        flash_sck_out,
    input wire logic [3:0]  flash_cs_n_out,
    input wire logic        flash_pause_n_out,
    // status and core
    input wire logic        config_status_out,
    input wire logic        cmem_clear_out,
    input wire logic        core_rst_n_out,
    input wire logic        cfg_wr_out,
    input wire logic        test_do_out
);
    logic [15:0] up_q;
    always @(posedge mclk_in) begin
        if (!rstn_in)
            up_q <= 16'h0000;
        else if (up_q != 16'hFFFF)
            up_q <= up_q + 16'h0001;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    hk_len_a: assert property ($rose(config_status_out) |->
        up_q >= HK_CNT - 1 && up_q <= HK_CNT + 1) else $error("status rise time");
    hk_busy_a: assert property (!config_status_out |-> host_busy_out)
        else $error("not busy in housekeeping");
    status_hold_a: assert property (config_status_out |=> config_status_out)
        else $error("status fell");
    clear_early_a: assert property (cmem_clear_out |-> !config_status_out)
        else $error("clear after housekeeping");
    cs_single_a: assert property (!flash_quad_in |-> flash_cs_n_out[3:1] == 3'h7)
        else $error("upper select in single mode");
    cs_one_a: assert property ($onehot0(~flash_cs_n_out))
        else $error("two selects low");
    pins_own_a: assert property (flash_mode_in |-> dq_oe_n_out && !dq_valid_out)
        else $error("host port drives in flash mode");
    valid_drive_a: assert property (dq_valid_out |-> !dq_oe_n_out)
        else $error("valid while pins released");
    sck_half_a: assert property ($changed(flash_sck_out) |=> $stable(flash_sck_out) [*3])
        else $error("serial clock half period");
    pause_edge_a: assert property ($changed(flash_pause_n_out) |-> $fell(flash_sck_out))
        else $error("pause off clock fall");
    pause_run_a: assert property ($fell(flash_pause_n_out) |->
        flash_cs_n_out != 4'hF ##[1:8] $changed(flash_sck_out)) else $error("pause stops clock");
    wr_pulse_a: assert property (cfg_wr_out |=> !cfg_wr_out)
        else $error("write strobe too long");
    core_after_a: assert property (core_rst_n_out |-> config_status_out)
        else $error("core out of reset early");
    test_rst_a: assert property (!test_port_reset_n_in |-> !test_do_out)
        else $error("test out not cleared");
    cover property ($rose(config_status_out));
    cover property (cfg_wr_out);
    cover property (dq_valid_out);
    cover property ($fell(flash_pause_n_out));
endmodule // config_unit_front_chk
`default_nettype wire

// ===== tb/host_far_end.sv
// Purpose: host processor and serial flash beside the device
// Assumes: host clock 125 ns, runs only in group and idle, stands still otherwise
// Notes:   released lines show the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
module host_far_end (
    // device status
    input  wire logic        host_busy_in,
    input  wire logic        flash_mode_in,
    input  wire logic        flash_sck_in,
    input  wire logic        flash_pause_n_in,
    // pins toward the device
    output var  logic        host_clk_out,
    output var  logic        host_cs_n_out,
    output wire logic [31:0] dq_drv_out
);
    logic [31:0] hq_q = 32'h0000_0000;
    logic [31:0] fd_q = 32'h0000_0000;
    logic        adv_q = 1'b0;
    logic        to_q = 1'b0;
    logic [31:0] fq[$];
    initial host_clk_out = 1'b1;
    initial host_cs_n_out = 1'b1;
    assign dq_drv_out = flash_mode_in ? fd_q : hq_q;
    task word(input logic [31:0] w);
        host_clk_out = 1'b0;
        hq_q = w;
        #62.5;
        host_clk_out = 1'b1;
        #62.5;
    endtask
    task group(input logic [127:0] g, input logic heed);
        int k;
        for (k = 0; k < 400 && heed && host_busy_in; k++) #10;
        if (heed && host_busy_in) to_q = 1'b1;
        host_cs_n_out = 1'b0;
        for (k = 0; k < 4; k++) word(g[127-32*k -: 32]);
        host_clk_out = 1'b0;
        hq_q = ~hq_q;
        host_cs_n_out = 1'b1;
    endtask
    task idle(input int n);
        int k;
        for (k = 0; k < n; k++) begin
            host_clk_out = 1'b1;
            #62.5;
            host_clk_out = 1'b0;
            hq_q = ~hq_q;
            #62.5;
        end
    endtask
    task load(input logic [31:0] w);
        fq.push_back(w);
        fd_q = fq[0];
    endtask
    // flash shifts only when not held
    always @(posedge flash_sck_in) adv_q <= flash_pause_n_in;
    always @(negedge flash_sck_in) begin
        if (adv_q && fq.size() > 0)
            void'(fq.pop_front());
        fd_q <= (fq.size() > 0) ? fq[0] : ~fd_q;
    end
endmodule // host_far_end
`default_nettype wire

// ===== tb/config_unit_front_tb.sv
// Purpose: self-checking bench for config_unit_front
// Assumes: host clock 125 ns, shortened counts
// Notes:   flash scenario runs last
`timescale 1ns/100ps
`default_nettype none
`include "cfg_front_consts.vh"
module config_unit_front_tb;
    localparam HK = 128;
    localparam ST = 4;
    logic        mclk_in, rstn_in, flash_mode_in, flash_go_in, flash_quad_in;
    logic        flash_pause_req_in, test_port_reset_n_in, test_clk_in, test_mode_in;
    logic        test_di_in, saw_clr;
    logic [2:0]  test_strap_in;
    logic [1:0]  flash_sel_in;
    logic [31:0] rd_q;
    logic [57:0] wq[$];
    int          n_fail, checks, rd_n, i;
    wire  [31:0] dq_out, dq_drv, cfg_data_out;
    wire  [23:0] cfg_addr_out;
    wire  [3:0]  flash_cs_n_out;
    wire  [1:0]  cfg_tgt_out;
    wire         host_clk, host_cs_n, dq_oe_n_out, dq_valid_out, host_busy_out;
    wire         flash_sck_out, flash_pause_n_out, config_status_out, cmem_clear_out;
    wire         core_rst_n_out, cfg_wr_out, test_do_out;
    wire  [31:0] dq_in = !dq_oe_n_out ? dq_out : dq_drv;
    config_unit_front #(.HK_CNT(HK), .START_CNT(ST)) DUT (.mclk_in, .rstn_in,
        .host_clk_in(host_clk), .host_cs_n_in(host_cs_n), .dq_in, .dq_out, .dq_oe_n_out,
        .dq_valid_out, .host_busy_out, .flash_mode_in, .test_strap_in, .flash_go_in,
        .flash_quad_in, .flash_sel_in, .flash_pause_req_in, .flash_sck_out, .flash_cs_n_out,
        .flash_pause_n_out, .config_status_out, .cmem_clear_out, .core_rst_n_out, .cfg_wr_out,
        .cfg_tgt_out, .cfg_addr_out, .cfg_data_out, .test_port_reset_n_in, .test_clk_in,
        .test_mode_in, .test_di_in, .test_do_out);
    host_far_end hf (.host_busy_in(host_busy_out), .flash_mode_in,
        .flash_sck_in(flash_sck_out), .flash_pause_n_in(flash_pause_n_out),
        .host_clk_out(host_clk), .host_cs_n_out(host_cs_n), .dq_drv_out(dq_drv));
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (cfg_wr_out === 1'b1)
            wq.push_back({cfg_tgt_out, cfg_addr_out, cfg_data_out});
        if (dq_valid_out === 1'b1) begin
            rd_q <= dq_out;
            rd_n <= rd_n + 1;
        end
        if (cmem_clear_out === 1'b1)
            saw_clr <= 1'b1;
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    function logic [31:0] pk(input logic [3:0] op, input logic [23:0] a);
        return {op, 4'h0, a};
    endfunction
    task expw(input logic [1:0] t, input logic [23:0] a, input logic [31:0] d);
        for (i = 0; i < 300 && wq.size() == 0; i++) @(negedge mclk_in);
        chk({6'h00, (wq.size() > 0) ? wq.pop_front() : 58'h0}, {6'h00, t, a, d});
    endtask
    task s_hk;
        chk({62'h0, config_status_out, host_busy_out}, 64'h1);
        hf.group({pk(`OP_REG_WRITE, 24'h00_0007), 32'h1234_5678, 64'h0}, 1'b0);
        for (i = 0; i < 400 && config_status_out !== 1'b1; i++) @(negedge mclk_in);
        repeat (4) @(negedge mclk_in);
        chk({62'h0, config_status_out, host_busy_out}, 64'h2);
        chk({63'h0, saw_clr}, 64'h1);
        chk(wq.size(), 64'h0);
    endtask
    task s_write;
        hf.group({pk(`OP_REG_WRITE, 24'h00_0005), 32'hA5A5_5A5A,
            pk(`OP_CMEM_WRITE, 24'h12_3456), 32'h0BAD_F00D}, 1'b1);
        expw(`TGT_CTRL, 24'h00_0005, 32'hA5A5_5A5A);
        expw(`TGT_CMEM, 24'h12_3456, 32'h0BAD_F00D);
        hf.group({pk(`OP_RING_WRITE, 24'h00_0ABC), 32'h1111_2222, 32'h0,
            pk(`OP_REG_WRITE, 24'h00_0006)}, 1'b1);
        hf.group({32'h3333_4444, 96'h0}, 1'b1);
        expw(`TGT_RING, 24'h00_0ABC, 32'h1111_2222);
        expw(`TGT_CTRL, 24'h00_0006, 32'h3333_4444);
    endtask
    task s_read;
        rd_n = 0;
        hf.group({96'h0, pk(`OP_REG_READ, 24'h00_0005)}, 1'b1);
        hf.idle(12);
        chk({31'h0, rd_n > 0, rd_q}, {31'h0, 1'b1, 32'hA5A5_5A5A});
    endtask
    task s_run;
        hf.group({pk(`OP_REG_WRITE, 24'h00_0000), 32'h0000_0001, 64'h0}, 1'b1);
        expw(`TGT_CTRL, 24'h00_0000, 32'h0000_0001);
        chk({63'h0, core_rst_n_out}, 64'h0);
        for (i = 0; i < 3 * ST && core_rst_n_out !== 1'b1; i++) @(negedge mclk_in);
        chk({63'h0, core_rst_n_out}, 64'h1);
        hf.group({pk(`OP_REG_WRITE, 24'h00_0000), 32'hFFFF_FFFE, 64'h0}, 1'b1);
        expw(`TGT_CTRL, 24'h00_0000, 32'hFFFF_FFFE);
        @(negedge mclk_in);
        chk({63'h0, core_rst_n_out}, 64'h0);
    endtask
    task s_strap;
        test_strap_in = 3'h1;
        hf.group({pk(`OP_REG_WRITE, 24'h00_0007), 32'h5555_AAAA, 64'h0}, 1'b1);
        repeat (40) @(negedge mclk_in);
        chk(wq.size(), 64'h0);
        test_strap_in = 3'h0;
    endtask
    task s_test;
        test_port_reset_n_in = 1'b0;
        @(negedge mclk_in);
        chk({63'h0, test_do_out}, 64'h0);
        test_port_reset_n_in = 1'b1;
        test_di_in = 1'b1;
        repeat (4) begin
            test_clk_in = 1'b1;
            repeat (4) @(negedge mclk_in);
            test_clk_in = 1'b0;
            repeat (4) @(negedge mclk_in);
        end
        chk({63'h0, test_do_out}, 64'h1);
    endtask
    task s_flash;
        flash_mode_in = 1'b1;
        flash_quad_in = 1'b1;
        flash_sel_in = 2'h2;
        flash_pause_req_in = 1'b1;
        hf.load(pk(`OP_REG_WRITE, 24'h00_0009));
        hf.load(32'h9999_0000);
        hf.load(32'h0000_0000);
        hf.load(32'h0000_0000);
        flash_go_in = 1'b1;
        for (i = 0; i < 200 && flash_pause_n_out !== 1'b0; i++) @(negedge mclk_in);
        chk({60'h0, flash_cs_n_out}, 64'hB);
        chk({63'h0, flash_pause_n_out}, 64'h0);
        repeat (60) @(negedge mclk_in);
        chk(wq.size(), 64'h0);
        flash_pause_req_in = 1'b0;
        expw(`TGT_CTRL, 24'h00_0009, 32'h9999_0000);
        flash_go_in = 1'b0;
    endtask
    task tally_and_finish;
        chk({63'h0, hf.to_q}, 64'h0);
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {rstn_in, flash_mode_in, flash_go_in, flash_quad_in, flash_pause_req_in} = 5'h00;
        {test_clk_in, test_mode_in, test_di_in, saw_clr} = 4'h0;
        test_port_reset_n_in = 1'b1;
        test_strap_in = 3'h0;
        flash_sel_in = 2'h0;
        {n_fail, checks, rd_n} = '0;
        repeat (3) @(negedge mclk_in);
        rstn_in = 1'b1;
        s_hk;
        s_write;
        s_read;
        s_run;
        s_strap;
        s_test;
        s_flash;
        tally_and_finish;
    end
endmodule // config_unit_front_tb
bind config_unit_front config_unit_front_chk #(.HK_CNT(HK_CNT)) u_chk (.mclk_in, .rstn_in,
    .flash_mode_in, .flash_quad_in, .test_port_reset_n_in, .dq_oe_n_out, .dq_valid_out,
    .host_busy_out, .flash_sck_out, .flash_cs_n_out, .flash_pause_n_out, .config_status_out,
    .cmem_clear_out, .core_rst_n_out, .cfg_wr_out, .test_do_out);
`default_nettype wire
